/* hdl/olcr_regs.sv */
`timescale 1ns/1ps
`include "olcr_cfg.svh"

module olcr_regs
    import olcr_pkg::*;
#(
    parameter int TICK_CYCLES = `OLCR_TICK_CYCLES,
    parameter logic [7:0] BCAST_ADDR = 8'hFF,
    parameter logic [7:0] OFF_OPCODE = 8'h00,
    parameter logic [7:0] RECALL_OPCODE = 8'h01
) (
    // Clock and reset.
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Register access port.
    input wire logic [15:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    output logic reg_rvalid_out,
    // Physical contacts.
    input wire logic occupancy_input_a_in,
    input wire logic occupancy_input_b_in,
    input wire logic switch_input_a_in,
    input wire logic switch_input_b_in,
    // Results toward the control and lighting logic.
    output logic occupancy_held_a_out,
    output logic occupancy_held_b_out,
    output logic switch_a_effective_out,
    output logic switch_b_effective_out,
    output logic network1_power_state_out,
    output logic network2_power_state_out,
    output olcr_cmd_type network1_cmd_out,
    output olcr_cmd_type network2_cmd_out
);

    // ======================================================================
    // Elaboration checks.
    if (TICK_CYCLES < 2) begin : g_bad_tick
        $error("TICK_CYCLES must be at least 2");
    end

    // ======================================================================
    // Decoding helpers.
    function automatic logic is_write(input logic [15:0] addr, input logic [15:0] target);
        is_write = reg_wr_in && (addr == target);
    endfunction

    function automatic logic motion_of(input logic contact, input logic [15:0] pol);
        motion_of = (pol == `OLCR_POL_MAKE) ? contact : !contact;
    endfunction

    function automatic olcr_cmd_type make_cmd(input logic fire, input logic [7:0] opcode);
        make_cmd.valid = fire;
        make_cmd.addr = BCAST_ADDR;
        make_cmd.opcode = opcode;
    endfunction

    logic [15:0] pol_a_reg;
    logic [15:0] pol_b_reg;
    logic [15:0] hold_a_reg;
    logic [15:0] hold_b_reg;
    logic [31:0] tick_cnt_reg;
    logic tick_reg;
    logic [15:0] left_a_reg;
    logic [15:0] left_b_reg;
    olcr_occ_state_type occ_a_reg;
    olcr_occ_state_type occ_b_reg;
    logic [1:0] trig1_reg;
    logic [1:0] trig2_reg;
    logic override_a_reg;
    logic override_b_reg;
    logic override_on_reg;
    logic motion_a;
    logic motion_b;
    logic bank_wr;
    logic n1_off;
    logic n1_rec;
    logic n2_off;
    logic n2_rec;

    // ======================================================================
    // Polarity registers; values other than make or break are ignored
    // so the detector never runs with an undefined contact sense.
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            pol_a_reg <= `OLCR_POL_BREAK;
            pol_b_reg <= `OLCR_POL_BREAK;
        end else begin
            if (is_write(reg_addr_in, `OLCR_ADDR_POL_A) &&
                (reg_wdata_in == `OLCR_POL_MAKE || reg_wdata_in == `OLCR_POL_BREAK)) begin
                pol_a_reg <= reg_wdata_in;
            end
            if (is_write(reg_addr_in, `OLCR_ADDR_POL_B) &&
                (reg_wdata_in == `OLCR_POL_MAKE || reg_wdata_in == `OLCR_POL_BREAK)) begin
                pol_b_reg <= reg_wdata_in;
            end
        end
    end

    // ======================================================================
    // Hold-time registers in seconds.
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            hold_a_reg <= `OLCR_HOLD_RESET;
            hold_b_reg <= `OLCR_HOLD_RESET;
        end else begin
            if (is_write(reg_addr_in, `OLCR_ADDR_HOLD_A)) begin
                hold_a_reg <= reg_wdata_in;
            end
            if (is_write(reg_addr_in, `OLCR_ADDR_HOLD_B)) begin
                hold_b_reg <= reg_wdata_in;
            end
        end
    end

    // ======================================================================
    // One-second tick as a single-cycle enable.
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            tick_cnt_reg <= 32'h00000000;
            tick_reg <= 1'b0;
        end else if (tick_cnt_reg == 32'(TICK_CYCLES - 1)) begin
            tick_cnt_reg <= 32'h00000000;
            tick_reg <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
            tick_reg <= 1'b0;
        end
    end

    assign motion_a = motion_of(occupancy_input_a_in, pol_a_reg);
    assign motion_b = motion_of(occupancy_input_b_in, pol_b_reg);

    // ======================================================================
    // Hold-off countdown. The count is loaded with the full hold time and
    // expires on the tick after it reaches zero, so the light stays on
    // between N and N+1 seconds: never shorter than programmed.
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            occ_a_reg <= OLCR_OCC_IDLE;
            left_a_reg <= 16'h0000;
        end else if (motion_a) begin
            occ_a_reg <= OLCR_OCC_HELD;
            left_a_reg <= hold_a_reg;
        end else if (tick_reg && occ_a_reg == OLCR_OCC_HELD) begin
            case (left_a_reg)
                16'h0000: occ_a_reg <= OLCR_OCC_IDLE;
                default: left_a_reg <= left_a_reg - 16'h0001;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            occ_b_reg <= OLCR_OCC_IDLE;
            left_b_reg <= 16'h0000;
        end else if (motion_b) begin
            occ_b_reg <= OLCR_OCC_HELD;
            left_b_reg <= hold_b_reg;
        end else if (tick_reg && occ_b_reg == OLCR_OCC_HELD) begin
            case (left_b_reg)
                16'h0000: occ_b_reg <= OLCR_OCC_IDLE;
                default: left_b_reg <= left_b_reg - 16'h0001;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            occupancy_held_a_out <= 1'b0;
            occupancy_held_b_out <= 1'b0;
        end else begin
            occupancy_held_a_out <= (occ_a_reg == OLCR_OCC_HELD);
            occupancy_held_b_out <= (occ_b_reg == OLCR_OCC_HELD);
        end
    end

    // ======================================================================
    // Command bank decode. Off wins over recall when one write asks both.
    assign bank_wr = is_write(reg_addr_in, `OLCR_ADDR_CMD_BANK);
    assign n1_off = bank_wr &&
        ((network1_power_state_out && !reg_wdata_in[`OLCR_BIT_NET1_POWER]) ||
         (!trig1_reg[1] && reg_wdata_in[`OLCR_BIT_NET1_OFF]));
    assign n1_rec = bank_wr && !n1_off &&
        ((!network1_power_state_out && reg_wdata_in[`OLCR_BIT_NET1_POWER]) ||
         (!trig1_reg[0] && reg_wdata_in[`OLCR_BIT_NET1_RECALL]));
    assign n2_off = bank_wr &&
        ((network2_power_state_out && !reg_wdata_in[`OLCR_BIT_NET2_POWER]) ||
         (!trig2_reg[1] && reg_wdata_in[`OLCR_BIT_NET2_OFF]));
    assign n2_rec = bank_wr && !n2_off &&
        ((!network2_power_state_out && reg_wdata_in[`OLCR_BIT_NET2_POWER]) ||
         (!trig2_reg[0] && reg_wdata_in[`OLCR_BIT_NET2_RECALL]));

    // Trigger bits are remembered so that only a rising edge fires.
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            trig1_reg <= 2'b00;
            trig2_reg <= 2'b00;
        end else if (bank_wr) begin
            trig1_reg <= {reg_wdata_in[`OLCR_BIT_NET1_OFF], reg_wdata_in[`OLCR_BIT_NET1_RECALL]};
            trig2_reg <= {reg_wdata_in[`OLCR_BIT_NET2_OFF], reg_wdata_in[`OLCR_BIT_NET2_RECALL]};
        end
    end

    // Power state follows the last command sent to each network.
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            network1_power_state_out <= 1'b0;
            network2_power_state_out <= 1'b0;
        end else begin
            if (n1_off || n1_rec) begin
                network1_power_state_out <= n1_rec;
            end
            if (n2_off || n2_rec) begin
                network2_power_state_out <= n2_rec;
            end
        end
    end

    // Commands always carry the broadcast address.
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            network1_cmd_out <= '0;
            network2_cmd_out <= '0;
        end else begin
            network1_cmd_out <= make_cmd(n1_off || n1_rec,
                n1_off ? OFF_OPCODE : RECALL_OPCODE);
            network2_cmd_out <= make_cmd(n2_off || n2_rec,
                n2_off ? OFF_OPCODE : RECALL_OPCODE);
        end
    end

    // ======================================================================
    // Switch overrides take effect from the first bank write onward;
    // until then the physical switches pass through untouched.
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            override_on_reg <= 1'b0;
            override_a_reg <= 1'b0;
            override_b_reg <= 1'b0;
        end else if (bank_wr) begin
            override_on_reg <= 1'b1;
            override_a_reg <= reg_wdata_in[`OLCR_BIT_SW_A];
            override_b_reg <= reg_wdata_in[`OLCR_BIT_SW_B];
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            switch_a_effective_out <= 1'b0;
            switch_b_effective_out <= 1'b0;
        end else begin
            switch_a_effective_out <= override_on_reg ? override_a_reg : switch_input_a_in;
            switch_b_effective_out <= override_on_reg ? override_b_reg : switch_input_b_in;
        end
    end

    // ======================================================================
    // Read path; unmapped addresses read as zero.
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            reg_rdata_out <= 16'h0000;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in) begin
                case (reg_addr_in)
                    `OLCR_ADDR_RAW_STATUS: reg_rdata_out <= {14'h0000,
                        occupancy_input_b_in, occupancy_input_a_in};
                    `OLCR_ADDR_HELD_STATUS: reg_rdata_out <= {14'h0000,
                        occupancy_held_b_out, occupancy_held_a_out};
                    `OLCR_ADDR_POL_A: reg_rdata_out <= pol_a_reg;
                    `OLCR_ADDR_POL_B: reg_rdata_out <= pol_b_reg;
                    `OLCR_ADDR_HOLD_A: reg_rdata_out <= hold_a_reg;
                    `OLCR_ADDR_HOLD_B: reg_rdata_out <= hold_b_reg;
                    `OLCR_ADDR_CMD_BANK: reg_rdata_out <= {8'h00, override_b_reg,
                        trig2_reg, network2_power_state_out, override_a_reg,
                        trig1_reg, network1_power_state_out};
                    default: reg_rdata_out <= 16'h0000;
                endcase
            end
        end
    end

    // ======================================================================
    // Checks.
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    sequence seq_bank_write(int bit_idx, logic val);
        bank_wr && reg_wdata_in[bit_idx] == val;
    endsequence

    chk_pol_reject: assert property (
        reg_wr_in && reg_addr_in == `OLCR_ADDR_POL_A && reg_wdata_in != `OLCR_POL_MAKE &&
        reg_wdata_in != `OLCR_POL_BREAK |=> $stable(pol_a_reg))
        else $error("Polarity A took an invalid value.");
    chk_motion_holds: assert property (
        motion_a |=> ##1 occupancy_held_a_out)
        else $error("Motion on A did not raise held status.");
    chk_hold_expiry: assert property (
        tick_reg && !motion_a && occ_a_reg == OLCR_OCC_HELD && left_a_reg == 16'h0000
        |=> occ_a_reg == OLCR_OCC_IDLE ##1 !occupancy_held_a_out)
        else $error("Hold A did not expire.");
    chk_restart_load: assert property (
        motion_b |=> left_b_reg == $past(hold_b_reg) && occ_b_reg == OLCR_OCC_HELD)
        else $error("Countdown B not restarted.");
    chk_net1_off_fall: assert property (
        network1_power_state_out and seq_bank_write(`OLCR_BIT_NET1_POWER, 1'b0)
        |=> network1_cmd_out.valid && network1_cmd_out.opcode == OFF_OPCODE
            && !network1_power_state_out)
        else $error("Network 1 off not sent.");
    chk_net1_recall_rise: assert property (
        !trig1_reg[0] and seq_bank_write(`OLCR_BIT_NET1_RECALL, 1'b1)
        and (!reg_wdata_in[`OLCR_BIT_NET1_OFF]
            && (reg_wdata_in[`OLCR_BIT_NET1_POWER] || !network1_power_state_out))
        |=> network1_cmd_out.valid && network1_cmd_out.opcode == RECALL_OPCODE)
        else $error("Network 1 recall not sent.");
    chk_net2_off_rise: assert property (
        !trig2_reg[1] and seq_bank_write(`OLCR_BIT_NET2_OFF, 1'b1)
        |=> network2_cmd_out.valid && network2_cmd_out.opcode == OFF_OPCODE)
        else $error("Network 2 off not sent.");
    chk_bcast_addr: assert property (
        network1_cmd_out.valid || network2_cmd_out.valid
        |-> network1_cmd_out.addr == BCAST_ADDR && network2_cmd_out.addr == BCAST_ADDR)
        else $error("Command without broadcast address.");
    chk_switch_force: assert property (
        bank_wr |=> ##1 switch_a_effective_out == $past(reg_wdata_in[`OLCR_BIT_SW_A], 2))
        else $error("Switch A override not applied.");
    chk_raw_read: assert property (
        reg_rd_in && reg_addr_in == `OLCR_ADDR_RAW_STATUS
        |=> reg_rvalid_out && reg_rdata_out[0] == $past(occupancy_input_a_in))
        else $error("Raw status read wrong.");

endmodule

/* hdl/olcr_cfg.svh */
`ifndef OLCR_CFG_SVH
`define OLCR_CFG_SVH

// ==========================================================================
// Register offsets.
`define OLCR_ADDR_RAW_STATUS 16'h759B
`define OLCR_ADDR_HELD_STATUS 16'h75C4
`define OLCR_ADDR_POL_A 16'h9CA7
`define OLCR_ADDR_POL_B 16'h9CA8
`define OLCR_ADDR_HOLD_A 16'h9CAB
`define OLCR_ADDR_HOLD_B 16'h9CAC
`define OLCR_ADDR_CMD_BANK 16'h9D3D

// ==========================================================================
// Polarity encodings and reset values.
`define OLCR_POL_MAKE 16'h0005
`define OLCR_POL_BREAK 16'h0006
`define OLCR_HOLD_RESET 16'h012C

// ==========================================================================
// Field positions in the lighting command bank.
`define OLCR_BIT_NET1_POWER 0
`define OLCR_BIT_NET1_RECALL 1
`define OLCR_BIT_NET1_OFF 2
`define OLCR_BIT_SW_A 3
`define OLCR_BIT_NET2_POWER 4
`define OLCR_BIT_NET2_RECALL 5
`define OLCR_BIT_NET2_OFF 6
`define OLCR_BIT_SW_B 7

// ==========================================================================
// Timing: one-second tick at a 100 MHz system clock.
`define OLCR_TICK_SECONDS 1
`define OLCR_CLK_HZ 100000000
`define OLCR_TICK_CYCLES (`OLCR_TICK_SECONDS * `OLCR_CLK_HZ)

`endif

/* hdl/olcr_pkg.sv */
package olcr_pkg;

    // One lighting command as handed to the frame encoder.
    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [7:0] opcode;
    } olcr_cmd_type;

    // Hold-off state of one occupancy input.
    typedef enum logic [1:0] {
        OLCR_OCC_IDLE = 2'b00,
        OLCR_OCC_HELD = 2'b01
    } olcr_occ_state_type;

endpackage

/* tb/olcr_ballast_model.sv */
`timescale 1ns/1ps

// ==========================================================================
// Ballast network on one lighting line, acting only on broadcast frames.
module olcr_ballast_model
    import olcr_pkg::*;
#(
    parameter logic [7:0] BCAST_ADDR = 8'hFF,
    parameter logic [7:0] OFF_OPCODE = 8'h00,
    parameter logic [7:0] RECALL_OPCODE = 8'h01
) (
    // Clock and reset.
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Command frames from the register bank.
    input wire olcr_cmd_type cmd_in,
    // Observed state of the gear.
    output logic lamp_on_out,
    output logic [15:0] recall_count_out,
    output logic [15:0] off_count_out,
    output logic [15:0] stray_count_out
);
    // Gear without short addresses answers broadcast only, so any other
    // address or opcode is counted as stray and changes nothing.
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            lamp_on_out <= 1'b0;
            recall_count_out <= 16'h0000;
            off_count_out <= 16'h0000;
            stray_count_out <= 16'h0000;
        end else if (cmd_in.valid === 1'b1) begin
            if (cmd_in.addr !== BCAST_ADDR) begin
                stray_count_out <= stray_count_out + 16'h0001;
            end else if (cmd_in.opcode === OFF_OPCODE) begin
                lamp_on_out <= 1'b0;
                off_count_out <= off_count_out + 16'h0001;
            end else if (cmd_in.opcode === RECALL_OPCODE) begin
                lamp_on_out <= 1'b1;
                recall_count_out <= recall_count_out + 16'h0001;
            end else begin
                stray_count_out <= stray_count_out + 16'h0001;
            end
        end
    end
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
`include "olcr_cfg.svh"

// ==========================================================================
// Self-checking bench for the occupancy and lighting command registers.
module tb
    import olcr_pkg::*;
;
    logic clk_sys_in, rst_in, reg_wr, reg_rd, rvalid, occ_a, occ_b, sw_a, sw_b;
    logic [15:0] reg_addr, reg_wdata, rdata;
    logic held_a, held_b, eff_a, eff_b, pwr1, pwr2, lamp1, lamp2;
    logic [15:0] rc1, oc1, sc1, rc2, oc2, sc2;
    olcr_cmd_type cmd1, cmd2;
    int fail_count = 0;
    int checked = 0;

    // A short tick keeps the 300 second default hold within a few thousand cycles.
    olcr_regs #(.TICK_CYCLES(10)) u_dut (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .reg_addr_in(reg_addr), .reg_wr_in(reg_wr), .reg_wdata_in(reg_wdata),
        .reg_rd_in(reg_rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .occupancy_input_a_in(occ_a), .occupancy_input_b_in(occ_b),
        .switch_input_a_in(sw_a), .switch_input_b_in(sw_b),
        .occupancy_held_a_out(held_a), .occupancy_held_b_out(held_b),
        .switch_a_effective_out(eff_a), .switch_b_effective_out(eff_b),
        .network1_power_state_out(pwr1), .network2_power_state_out(pwr2),
        .network1_cmd_out(cmd1), .network2_cmd_out(cmd2));
    olcr_ballast_model u_net1 (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .cmd_in(cmd1),
        .lamp_on_out(lamp1), .recall_count_out(rc1), .off_count_out(oc1),
        .stray_count_out(sc1));
    olcr_ballast_model u_net2 (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .cmd_in(cmd2),
        .lamp_on_out(lamp2), .recall_count_out(rc2), .off_count_out(oc2),
        .stray_count_out(sc2));

    // ======================================================================
    // Shared tasks: wr, rd and check start and end 1 ns after a rising edge.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        cyc(1);
        reg_wr = 1'b0;
        // An idle edge keeps the next call from raising the strobe in the same step.
        cyc(1);
    endtask

    // The wait is bounded so a missing answer cannot hang the run.
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        int n;
        reg_addr = a;
        reg_rd = 1'b1;
        cyc(1);
        reg_rd = 1'b0;
        n = 0;
        while (rvalid !== 1'b1 && n < 4) begin
            cyc(1);
            n++;
        end
        check({15'h0000, rvalid}, 16'h0001);
        d = rdata;
        cyc(1);
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ======================================================================
    // Scenarios.
    task automatic test_reset();
        logic [15:0] q;
        rd(`OLCR_ADDR_POL_A, q); check(q, 16'h0006);
        rd(`OLCR_ADDR_POL_B, q); check(q, 16'h0006);
        rd(`OLCR_ADDR_HOLD_A, q); check(q, 16'h012C);
        rd(`OLCR_ADDR_HOLD_B, q); check(q, 16'h012C);
        rd(16'h1234, q); check(q, 16'h0000);
        check({held_b, held_a}, 2'b00);
        $display("test reset_values done");
    endtask

    // Make contact on input A with a 3 second hold, then a retrigger.
    task automatic test_occ_a();
        logic [15:0] q;
        wr(`OLCR_ADDR_HOLD_A, 16'h0003);
        wr(`OLCR_ADDR_POL_A, `OLCR_POL_MAKE);
        wr(`OLCR_ADDR_POL_A, 16'h0007);
        rd(`OLCR_ADDR_POL_A, q); check(q, 16'h0005);
        rd(`OLCR_ADDR_RAW_STATUS, q); check(q, 16'h0003);
        occ_a = 1'b0;
        cyc(3); check(held_a, 1'b1);
        rd(`OLCR_ADDR_HELD_STATUS, q); check(q, 16'h0001);
        cyc(20); check(held_a, 1'b1);
        cyc(20); check(held_a, 1'b0);
        rd(`OLCR_ADDR_HELD_STATUS, q); check(q, 16'h0000);
        occ_a = 1'b1; cyc(1); occ_a = 1'b0; cyc(20);
        occ_a = 1'b1; cyc(1); occ_a = 1'b0; cyc(25);
        check(held_a, 1'b1);
        cyc(20); check(held_a, 1'b0);
        $display("test occupancy_a done");
    endtask

    // Break contact on input B opens once; the default hold applies.
    task automatic test_occ_b();
        logic [15:0] q;
        occ_b = 1'b0; cyc(1); occ_b = 1'b1;
        cyc(3); check(held_b, 1'b1);
        rd(`OLCR_ADDR_HELD_STATUS, q); check(q, 16'h0002);
        cyc(2980); check(held_b, 1'b1);
        cyc(40); check(held_b, 1'b0);
        $display("test occupancy_b done");
    endtask

    // Same step table for each network; switches are driven opposite to the
    // override bits so a pass-through would show.
    task automatic test_cmd();
        logic [7:0] seq [6] = '{8'h01, 8'h08, 8'h02, 8'h0B, 8'h05, 8'h0D};
        logic [0:5] rexp = 6'b101001;
        logic [0:5] oexp = 6'b010010;
        logic [1:0] st = 2'b00;
        logic [15:0] d, q, pr1, po1, pr2, po2;
        for (int n = 0; n < 2; n++) begin
            for (int i = 0; i < 6; i++) begin
                d = (n == 1) ? {8'h00, seq[i][3:0], 4'h1} : {8'h00, seq[i]};
                sw_a = ~d[3];
                sw_b = ~d[7];
                pr1 = rc1; po1 = oc1; pr2 = rc2; po2 = oc2;
                if (rexp[i]) st[n] = 1'b1;
                if (oexp[i]) st[n] = 1'b0;
                wr(`OLCR_ADDR_CMD_BANK, d);
                cyc(2);
                check(rc1 - pr1, (n == 0) ? rexp[i] : 1'b0);
                check(oc1 - po1, (n == 0) ? oexp[i] : 1'b0);
                check(rc2 - pr2, (n == 1) ? rexp[i] : 1'b0);
                check(oc2 - po2, (n == 1) ? oexp[i] : 1'b0);
                check({pwr2, pwr1}, st);
                check(eff_a, d[3]);
                check(eff_b, d[7]);
                rd(`OLCR_ADDR_CMD_BANK, q);
                check(q[0], st[0]);
                check(q[4], st[1]);
            end
        end
        check({lamp2, lamp1}, st);
        check(sc1 | sc2, 16'h0000);
        $display("test command_bank done");
    endtask

    // ======================================================================
    // Clock, stimulus sequence and watchdog.
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    initial begin
        rst_in = 1'b1; reg_addr = 16'h0000; reg_wdata = 16'h0000;
        reg_wr = 1'b0; reg_rd = 1'b0; occ_a = 1'b1; occ_b = 1'b1;
        sw_a = 1'b1; sw_b = 1'b0;
        cyc(8);
        rst_in = 1'b0;
        test_reset();
        test_occ_a();
        test_occ_b();
        test_cmd();
        conclude();
    end

    // The scenarios need about 3250 cycles; 20000 leaves ample margin.
    initial begin
        #200000;
        fail_count++;
        conclude();
    end
endmodule
